//--- sfsd_pkg.sv
/*
  shared constants and types for the serial flash status and command
  decoder. assumes nothing beyond a systemverilog compiler.
*/
package sfsd_pkg;
  // default array address width
  localparam int ADDR_W_DEF = 16;
  // opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_BLK_A = 8'h52;
  localparam logic [7:0] OP_BLK_B = 8'hd8;
  localparam logic [7:0] OP_CHIP_A = 8'h60;
  localparam logic [7:0] OP_CHIP_B = 8'hc7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_AAI = 8'haf;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_UNLOCK = 8'h50;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRDIS = 8'h04;
  localparam logic [7:0] OP_ID_A = 8'h90;
  localparam logic [7:0] OP_ID_B = 8'hab;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP0 = 2;
  localparam int ST_BP1 = 3;
  localparam int ST_AAI = 6;
  localparam int ST_LOCK = 7;
  // protect levels: power-up value and none
  localparam logic [1:0] BP_RST = 2'h3;
  localparam logic [1:0] BP_NONE = 2'h0;
  // byte indices within a frame
  localparam logic [2:0] BY_OPC = 3'h0;
  localparam logic [2:0] BY_ADDR_END = 3'h3;
  localparam logic [2:0] BY_RD_DATA = 3'h4;
  localparam logic [2:0] BY_FRD_DATA = 3'h5;
  localparam logic [2:0] BY_ID_DATA = 3'h5;
  localparam logic [2:0] BY_PROG_END = 3'h4;
  localparam logic [2:0] BY_LAST = 3'h7;
  // erase region sizes as address bits
  localparam int SECT_BITS = 12;
  localparam int BLK_BITS = 15;
  // identity bytes, values arbitrary
  localparam logic [7:0] ID_MFR_DEF = 8'h5a;
  localparam logic [7:0] ID_DEV_DEF = 8'h3c;

  // command captured at the end of a frame
  typedef enum logic [3:0] {
    X_NONE, X_WRITE_ENABLE_CMD, X_WRDIS, X_UNLOCK, X_STWR, X_CHIP,
    X_SECT, X_BLOCK, X_PROG, X_AAI1, X_AAIN
  } sfsd_exec_t;

  // array operation kinds
  typedef enum logic [1:0] {
    K_PROG, K_SECT, K_BLOCK, K_CHIP
  } sfsd_kind_t;

  // operation controller state, one-hot
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_BUSY = 2'b10
  } sfsd_state_t;

  typedef struct packed {
    sfsd_exec_t kind;
    logic [23:0] addr;
    logic [7:0] data;
  } sfsd_cmd_t;
endpackage

//--- sfsd_decode.sv
/*
  serial flash command decoder and status register. link logic runs on
  the serial clock, framed by chip select; status and operation control
  run on clk_sys. assumes an array controller on clk_sys that runs each
  started operation and pulses opDone, and an array read port on sck.
*/
module sfsd_decode
  import sfsd_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter logic [7:0] ID_MFR = ID_MFR_DEF,
  parameter logic [7:0] ID_DEV = ID_DEV_DEF
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // reset, high; async on the sck side, sync on clk_sys
  input wire logic wpN, // write protect pin
  input wire logic sck, // serial clock
  input wire logic csN, // chip select pin
  input wire logic mosi, // serial data in
  output logic soData, // serial data out
  output logic soOe, // serial out enable
  output logic [ADDR_W-1:0] arrAddr, // array read address
  input wire logic [7:0] arrRdData, // array read data
  output logic opStart, // start array op
  output sfsd_kind_t opKind, // array op kind
  output logic [ADDR_W-1:0] opAddr, // array op address
  output logic [7:0] opData, // program data
  input wire logic opDone, // array op finished
  output logic [7:0] flashStatus // status register
);

  // ---------------- link domain ----------------
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [2:0] byteCnt_r, byteCnt_nxt;
  logic [6:0] shift_r, shift_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [23:0] addr_r, addr_nxt;
  sfsd_cmd_t cmd_r, cmd_nxt;
  logic tog_r, tog_nxt;
  logic [7:0] statA_r, statB_r;
  logic soData_r, soOe_r;
  logic [7:0] newByte, txByte;
  logic aaiS, rdPh, stPh, idPh, txPh;

  assign newByte = {shift_r, mosi};
  assign aaiS = statB_r[ST_AAI];

  // output phases of the read-type instructions
  always_comb begin
    rdPh = (opc_r == OP_READ && byteCnt_r >= BY_RD_DATA) ||
      (opc_r == OP_FREAD && byteCnt_r >= BY_FRD_DATA);
    stPh = opc_r == OP_STAT_RD && byteCnt_r != BY_OPC;
    idPh = (opc_r == OP_ID_A || opc_r == OP_ID_B) &&
      byteCnt_r >= BY_ID_DATA;
    txPh = rdPh || stPh || idPh;
  end

  // shift, count and decode on each rising sck
  always_comb begin
    bitCnt_nxt = bitCnt_r + 3'h1;
    byteCnt_nxt = byteCnt_r;
    shift_nxt = newByte[6:0];
    opc_nxt = opc_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    tog_nxt = tog_r;
    if (bitCnt_r == 3'h0) begin
      cmd_nxt.kind = X_NONE;
      if (byteCnt_r == BY_OPC) begin
        tog_nxt = ~tog_r; // new frame seen
      end
    end
    if (bitCnt_r == 3'h7) begin
      if (byteCnt_r != BY_LAST) begin
        byteCnt_nxt = byteCnt_r + 3'h1;
      end
      if (byteCnt_r == BY_OPC) begin
        opc_nxt = newByte;
        case (newByte)
          OP_WRITE_ENABLE_CMD: cmd_nxt.kind = X_WRITE_ENABLE_CMD;
          OP_WRDIS: cmd_nxt.kind = X_WRDIS;
          OP_UNLOCK: cmd_nxt.kind = X_UNLOCK;
          OP_CHIP_A, OP_CHIP_B: cmd_nxt.kind = X_CHIP;
          default: cmd_nxt.kind = X_NONE;
        endcase
      end else if (byteCnt_r <= BY_ADDR_END) begin
        addr_nxt = {addr_r[15:0], newByte};
      end
      if (byteCnt_r == 3'h1) begin
        cmd_nxt.data = newByte;
        if (opc_r == OP_STAT_WR) begin
          cmd_nxt.kind = X_STWR;
        end else if (opc_r == OP_AAI && aaiS) begin
          cmd_nxt.kind = X_AAIN;
        end
      end
      if (byteCnt_r == BY_ADDR_END) begin
        cmd_nxt.addr = {addr_r[15:0], newByte};
        if (opc_r == OP_SECT) begin
          cmd_nxt.kind = X_SECT;
        end else if (opc_r == OP_BLK_A || opc_r == OP_BLK_B) begin
          cmd_nxt.kind = X_BLOCK;
        end
      end
      if (byteCnt_r == BY_PROG_END) begin
        cmd_nxt.data = newByte;
        if (opc_r == OP_PROG) begin
          cmd_nxt.kind = X_PROG;
        end else if (opc_r == OP_AAI && !aaiS) begin
          cmd_nxt.kind = X_AAI1;
        end
      end
      if (rdPh) begin
        addr_nxt = addr_r + 24'h1;
      end else if (idPh) begin
        addr_nxt[0] = ~addr_r[0];
      end
    end
  end

  // frame counters, cleared while select is high
  always_ff @(posedge sck or posedge csN or posedge reset) begin
    if (csN || reset) begin
      bitCnt_r <= 3'h0;
      byteCnt_r <= 3'h0;
    end else begin
      bitCnt_r <= bitCnt_nxt;
      byteCnt_r <= byteCnt_nxt;
    end
  end

  // received data and captured command survive the frame end
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      shift_r <= 7'h00;
      opc_r <= 8'h00;
      addr_r <= 24'h00_0000;
      cmd_r <= '{kind: X_NONE, addr: 24'h00_0000, data: 8'h00};
      tog_r <= 1'b0;
      statA_r <= 8'h00;
      statB_r <= 8'h00;
    end else begin
      shift_r <= shift_nxt;
      opc_r <= opc_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      tog_r <= tog_nxt;
      statA_r <= flashStatus; // status into sck domain
      statB_r <= statA_r;
    end
  end

  // byte to send in the current output phase
  always_comb begin
    if (stPh) begin
      txByte = statB_r;
    end else if (idPh) begin
      txByte = addr_r[0] ? ID_DEV : ID_MFR;
    end else begin
      txByte = arrRdData;
    end
  end

  // data leaves on the falling sck edge
  always_ff @(negedge sck or posedge csN or posedge reset) begin
    if (csN || reset) begin
      soData_r <= 1'b0;
      soOe_r <= 1'b0;
    end else begin
      soData_r <= txByte[3'h7 - bitCnt_r];
      soOe_r <= txPh;
    end
  end

  assign soData = soData_r;
  assign soOe = soOe_r;
  assign arrAddr = addr_r[ADDR_W-1:0];

  // ---------------- system domain ----------------
  sfsd_state_t state_r, state_nxt;
  logic wel_r, wel_nxt;
  logic [1:0] bp_r, bp_nxt;
  logic lock_r, lock_nxt;
  logic aai_r, aai_nxt;
  logic arm_r, arm_nxt;
  logic [ADDR_W-1:0] aaiAddr_r, aaiAddr_nxt;
  logic opStart_r, opStart_nxt;
  sfsd_kind_t opKind_r, opKind_nxt;
  logic [ADDR_W-1:0] opAddr_r, opAddr_nxt;
  logic [7:0] opData_r, opData_nxt;
  logic seen_r, seen_nxt;
  logic csA_r, csB_r, csC_r, togA_r, togB_r, wpA_r, wpB_r;
  logic take, aaiTop;
  logic [ADDR_W-1:0] cAddr, aaiNext, sMask, bMask;

  // protection test by level
  function automatic logic isProt(input logic [ADDR_W-1:0] a,
                                  input logic [1:0] lv);
    case (lv)
      2'h0: isProt = 1'b0;
      2'h1: isProt = &a[ADDR_W-1:ADDR_W-2];
      2'h2: isProt = a[ADDR_W-1];
      default: isProt = 1'b1;
    endcase
  endfunction

  // pin and frame-end synchronisers
  always_ff @(posedge clk_sys) begin
    csA_r <= csN;
    csB_r <= csA_r;
    csC_r <= csB_r;
    togA_r <= tog_r;
    togB_r <= togA_r;
    wpA_r <= wpN;
    wpB_r <= wpA_r;
  end

  // frame end with at least one clock edge seen
  assign take = csB_r && !csC_r && (togB_r != seen_r);
  assign cAddr = cmd_r.addr[ADDR_W-1:0];
  assign aaiNext = aaiAddr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign aaiTop = (&aaiAddr_r) || isProt(aaiNext, bp_r);
  assign sMask = {{(ADDR_W-SECT_BITS){1'b0}}, {SECT_BITS{1'b1}}};
  assign bMask = {{(ADDR_W-BLK_BITS){1'b0}}, {BLK_BITS{1'b1}}};

  // command execution and status update
  always_comb begin
    state_nxt = state_r;
    wel_nxt = wel_r;
    bp_nxt = bp_r;
    lock_nxt = lock_r;
    aai_nxt = aai_r;
    arm_nxt = arm_r;
    aaiAddr_nxt = aaiAddr_r;
    opStart_nxt = 1'b0;
    opKind_nxt = opKind_r;
    opAddr_nxt = opAddr_r;
    opData_nxt = opData_r;
    seen_nxt = take ? togB_r : seen_r;
    if (state_r == S_BUSY && opDone) begin
      state_nxt = S_IDLE;
      if (!aai_r) begin
        wel_nxt = 1'b0;
      end else if (aaiTop) begin
        aai_nxt = 1'b0;
        wel_nxt = 1'b0;
      end
    end
    if (take && state_r == S_IDLE) begin
      arm_nxt = 1'b0;
      case (cmd_r.kind)
        X_WRITE_ENABLE_CMD: wel_nxt = 1'b1;
        X_WRDIS: begin
          wel_nxt = 1'b0;
          aai_nxt = 1'b0;
        end
        X_UNLOCK: arm_nxt = 1'b1;
        X_STWR: begin
          if (arm_r && (wpB_r || !lock_r)) begin
            bp_nxt = {cmd_r.data[ST_BP1], cmd_r.data[ST_BP0]};
            lock_nxt = cmd_r.data[ST_LOCK];
          end
        end
        X_CHIP: begin
          if (wel_r && bp_r == BP_NONE) begin
            state_nxt = S_BUSY;
            opStart_nxt = 1'b1;
            opKind_nxt = K_CHIP;
          end
        end
        X_SECT: begin
          if (wel_r && !isProt(cAddr | sMask, bp_r)) begin
            state_nxt = S_BUSY;
            opStart_nxt = 1'b1;
            opKind_nxt = K_SECT;
            opAddr_nxt = cAddr & ~sMask;
          end
        end
        X_BLOCK: begin
          if (wel_r && !isProt(cAddr | bMask, bp_r)) begin
            state_nxt = S_BUSY;
            opStart_nxt = 1'b1;
            opKind_nxt = K_BLOCK;
            opAddr_nxt = cAddr & ~bMask;
          end
        end
        X_PROG, X_AAI1: begin
          if (wel_r && !aai_r && !isProt(cAddr, bp_r)) begin
            state_nxt = S_BUSY;
            opStart_nxt = 1'b1;
            opKind_nxt = K_PROG;
            opAddr_nxt = cAddr;
            opData_nxt = cmd_r.data;
            aaiAddr_nxt = cAddr;
            aai_nxt = cmd_r.kind == X_AAI1;
          end
        end
        X_AAIN: begin
          if (aai_r) begin
            state_nxt = S_BUSY;
            opStart_nxt = 1'b1;
            opKind_nxt = K_PROG;
            opAddr_nxt = aaiNext;
            opData_nxt = cmd_r.data;
            aaiAddr_nxt = aaiNext;
          end
        end
        default: arm_nxt = 1'b0;
      endcase
    end
  end

  // system state registers, power-up defaults
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= S_IDLE;
      wel_r <= 1'b0;
      bp_r <= BP_RST;
      lock_r <= 1'b0;
      aai_r <= 1'b0;
      arm_r <= 1'b0;
      aaiAddr_r <= '0;
      opStart_r <= 1'b0;
      opKind_r <= K_PROG;
      opAddr_r <= '0;
      opData_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wel_r <= wel_nxt;
      bp_r <= bp_nxt;
      lock_r <= lock_nxt;
      aai_r <= aai_nxt;
      arm_r <= arm_nxt;
      aaiAddr_r <= aaiAddr_nxt;
      opStart_r <= opStart_nxt;
      opKind_r <= opKind_nxt;
      opAddr_r <= opAddr_nxt;
      opData_r <= opData_nxt;
      seen_r <= seen_nxt;
    end
  end

  // status byte and operation outputs
  always_comb begin
    flashStatus = 8'h00;
    flashStatus[ST_BUSY] = state_r == S_BUSY;
    flashStatus[ST_WEL] = wel_r;
    flashStatus[ST_BP0] = bp_r[0];
    flashStatus[ST_BP1] = bp_r[1];
    flashStatus[ST_AAI] = aai_r;
    flashStatus[ST_LOCK] = lock_r;
  end

  assign opStart = opStart_r;
  assign opKind = opKind_r;
  assign opAddr = opAddr_r;
  assign opData = opData_r;

endmodule

//--- sfsd_decode_sva.sv
/*
  concurrent checks on the status and operation ports of the decoder.
  assumes the clk_sys domain and a bind onto every decoder instance.
*/
module sfsd_decode_sva
  import sfsd_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset
  input wire logic wpN, // protect pin
  input wire logic csN, // chip select
  input wire logic soOe, // out enable
  input wire logic opStart, // op launch
  input wire sfsd_kind_t opKind, // op kind
  input wire logic [ADDR_W-1:0] opAddr, // op address
  input wire logic opDone, // op end
  input wire logic [7:0] flashStatus // status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] topA;
  // highest address a program, sector or block operation touches
  always_comb begin
    topA = opAddr;
    if (opKind == K_SECT) topA = opAddr | ADDR_W'(16'h0fff);
    if (opKind == K_BLOCK) topA = opAddr | ADDR_W'(16'h7fff);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // plain operation finishing, then latch and busy drop
  sequence s_op_end;
    flashStatus[ST_BUSY] && opDone && !flashStatus[ST_AAI];
  endsequence
  sequence s_ready;
    !flashStatus[ST_WEL] && !flashStatus[ST_BUSY];
  endsequence
  property p_rst_val;
    $fell(reset) |-> flashStatus == 8'h0c;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("status not at power-up value");
  property p_busy_on;
    opStart |-> flashStatus[ST_BUSY] ##1 flashStatus[ST_BUSY];
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("busy not set by launch");
  property p_latch_req;
    opStart |-> $past(flashStatus[ST_WEL]);
  endproperty
  a_latch_req: assert property (p_latch_req)
    else $error("launch without write latch");
  property p_latch_clr;
    s_op_end |=> s_ready;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch or busy kept after completion");
  property p_chip;
    opStart && opKind == K_CHIP |-> $past(flashStatus[3:2]) == 2'b00;
  endproperty
  a_chip: assert property (p_chip)
    else $error("chip erase under protection");
  property p_prot;
    opStart |-> !($past(flashStatus[3]) && $past(flashStatus[2])
      || $past(flashStatus[3]) && topA[ADDR_W-1]
      || $past(flashStatus[2]) && topA[ADDR_W-1:ADDR_W-2] == 2'b11);
  endproperty
  a_prot: assert property (p_prot)
    else $error("launch into protected range");
  property p_busy_block;
    flashStatus[ST_BUSY] && !opDone |=> !opStart;
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("launch while busy");
  property p_rsvd;
    flashStatus[5:4] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved status bits set");
  property p_lock;
    !wpN && !$past(wpN) && !$past(wpN, 2) && flashStatus[ST_LOCK]
      |=> $stable({flashStatus[ST_LOCK], flashStatus[3:2]});
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked protect bits changed");
  property p_so_idle;
    csN |-> !soOe;
  endproperty
  a_so_idle: assert property (p_so_idle)
    else $error("output driven while deselected");
endmodule
bind sfsd_decode sfsd_decode_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clk_sys(clk_sys), .reset(reset), .wpN(wpN), .csN(csN), .soOe(soOe),
  .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .opDone(opDone),
  .flashStatus(flashStatus));

//--- sfsd_host_model.sv
/*
  spi host in mode 0: frames of msb-first bits with an 80 ns serial clock.
  each frame ends with 200 ns of idle after select rises; clock stands still between frames.
*/
module sfsd_host_model (
  output logic sck, // serial clock
  output logic csN, // chip select
  output logic mosi, // data to device
  input wire logic soData, // data from device
  input wire logic soOe // device drives out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // one frame, nBits sent from tx msb and captured into rx
  task automatic frame(input int nBits, input logic [63:0] tx,
                       output logic [63:0] rx);
    rx = '0;
    #7 csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      mosi = tx[63-i];
      #40 sck = 1'b1;
      rx = {rx[62:0], soOe ? soData : 1'bx};
      #40 sck = 1'b0;
    end
    #40 csN = 1'b1;
    mosi = ~mosi; // released line, not the last value
    #200;
  endtask
endmodule

//--- tb_spi_flash_status_and_command_decode.sv
/*
  self-checking bench for the decoder: host model on the link, array
  controller and array contents modelled here. assumes sfsd_pkg.
*/
module tb_spi_flash_status_and_command_decode;
  import sfsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, wpN, opDone, sck, csN, mosi, soData, soOe, opStart;
  logic [15:0] arrAddr, opAddr, a;
  logic [7:0] arrRdData, opData, flashStatus, d;
  logic [1:0] bp;
  logic [63:0] rx;
  sfsd_kind_t opKind;
  int miscompares, tests_run, starts;
  logic [7:0] ops [6] = '{OP_PROG, OP_SECT, OP_BLK_A, OP_BLK_B, OP_CHIP_A,
                          OP_CHIP_B};
  sfsd_kind_t kinds [6] = '{K_PROG, K_SECT, K_BLOCK, K_BLOCK, K_CHIP, K_CHIP};
  logic [15:0] masks [6] = '{16'hffff, 16'hf000, 16'h8000, 16'h8000,
                             16'h0000, 16'h0000};
  int lens [6] = '{40, 32, 32, 32, 8, 8};
  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // array contents
  function automatic logic [7:0] mem(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  assign arrRdData = mem(arrAddr);
  // launch counter
  always @(posedge clk_sys) if (opStart === 1'b1) starts++;
  sfsd_decode #(.ADDR_W(16)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .wpN(wpN), .sck(sck), .csN(csN), .mosi(mosi), .soData(soData),
    .soOe(soOe), .arrAddr(arrAddr), .arrRdData(arrRdData),
    .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .opData(opData),
    .opDone(opDone), .flashStatus(flashStatus));
  sfsd_host_model u_host (.sck(sck), .csN(csN), .mosi(mosi),
    .soData(soData), .soOe(soOe));
  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input int n, input logic [63:0] tx);
    u_host.frame(n, tx, rx);
  endtask
  // two status bytes read back to back
  task automatic stat(input logic [7:0] exp);
    cmd(24, {OP_STAT_RD, 56'h0});
    chk("status", {exp, exp}, rx[15:0]);
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    cmd(8, {OP_UNLOCK, 56'h0});
    cmd(16, {OP_STAT_WR, v, 48'h0});
  endtask
  task automatic done;
    @(negedge clk_sys) opDone = 1'b1;
    @(negedge clk_sys) opDone = 1'b0;
  endtask
  // array command, launched then completed, or refused
  task automatic arr(input logic en, input int n, input logic [63:0] tx,
      input logic go, input sfsd_kind_t k, input logic [15:0] ea,
      input logic [7:0] ed);
    int s0;
    if (en) cmd(8, {OP_WRITE_ENABLE_CMD, 56'h0});
    s0 = starts;
    cmd(n, tx);
    chk("launch", 16'(go), 16'(starts - s0));
    if (go) begin
      chk("kind", 16'(k), 16'(opKind));
      if (k != K_CHIP) chk("addr", ea, opAddr);
      if (k == K_PROG) chk("data", 16'(ed), 16'(opData));
      stat({4'h0, bp, 2'h3});
      cmd(8, {OP_WRDIS, 56'h0});
      done();
    end else begin
      cmd(8, {OP_WRDIS, 56'h0});
    end
    stat({4'h0, bp, 2'h0});
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    void'($urandom(32'h0000_b342));
    reset = 1'b0;
    wpN = 1'b1;
    opDone = 1'b0;
    bp = 2'h3;
    // a clean rising reset edge, clear of the time-zero ordering
    #1 reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    chk("reset", 8'h0c, flashStatus);
    repeat (3) @(negedge clk_sys);
    stat(8'h0c);
    cmd(5, {OP_WRITE_ENABLE_CMD, 56'h0});
    stat(8'h0c);
    cmd(16, {OP_STAT_WR, 8'h00, 48'h0});
    stat(8'h0c);
    status_write_cmd(8'hff);
    stat(8'h8c);
    @(negedge clk_sys) wpN = 1'b0;
    status_write_cmd(8'h00);
    stat(8'h8c);
    @(negedge clk_sys) wpN = 1'b1;
    status_write_cmd(8'h00);
    bp = 2'h0;
    stat(8'h00);
    a = 16'h0100;
    arr(0, 40, {OP_PROG, 8'h00, a, 8'h11, 24'h0}, 0, K_PROG, a, 0);
    for (int i = 0; i < 6; i++) begin
      a = 16'($urandom);
      d = 8'($urandom);
      arr(1, lens[i], {ops[i], 8'h00, a, d, 24'h0}, 1, kinds[i],
          a & masks[i], d);
    end
    for (int lv = 1; lv < 4; lv++) begin
      bp = 2'(lv);
      status_write_cmd({4'h0, bp, 2'h0});
      a = 16'($urandom) | 16'hc000;
      arr(1, 40, {OP_PROG, 8'h00, a, d, 24'h0}, 0, K_PROG, a, d);
      arr(1, 8, {OP_CHIP_A, 56'h0}, 0, K_CHIP, 0, 0);
      a = 16'($urandom) & 16'h3fff;
      arr(1, 40, {OP_PROG, 8'h00, a, d, 24'h0}, lv < 3, K_PROG, a, d);
    end
    a = 16'hffff;
    repeat (4) begin
      cmd(48, {OP_READ, 8'h00, a, 32'h0});
      chk("read", {mem(a), mem(a + 16'h0001)}, rx[15:0]);
      cmd(56, {OP_FREAD, 8'h00, a, 8'h00, 24'h0});
      chk("fast read", {mem(a), mem(a + 16'h0001)}, rx[15:0]);
      a = 16'($urandom);
    end
    cmd(56, {OP_ID_A, 16'h0, 8'h01, 8'h00, 24'h0});
    chk("id", {ID_DEV_DEF, ID_MFR_DEF}, rx[15:0]);
    cmd(56, {OP_ID_B, 16'h0, 8'h00, 8'h00, 24'h0});
    chk("id", {ID_MFR_DEF, ID_DEV_DEF}, rx[15:0]);
    bp = 2'h0;
    status_write_cmd(8'h00);
    a = 16'($urandom) & 16'h7ffe;
    cmd(8, {OP_WRITE_ENABLE_CMD, 56'h0});
    cmd(40, {OP_AAI, 8'h00, a, d, 24'h0});
    stat(8'h43);
    done();
    cmd(16, {OP_AAI, ~d, 48'h0});
    chk("next addr", a + 16'h0001, opAddr);
    done();
    stat(8'h42);
    cmd(8, {OP_WRDIS, 56'h0});
    stat(8'h00);
    // auto-increment started at the top address leaves the mode
    cmd(8, {OP_WRITE_ENABLE_CMD, 56'h0});
    cmd(40, {OP_AAI, 8'h00, 16'hffff, d, 24'h0});
    chk("top addr", 16'hffff, opAddr);
    done();
    stat(8'h00);
    results();
  end
endmodule
